// ---- rtl/static_bank_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the static bank control block
// Assumes: Word-aligned byte offsets on the plain register port
// Notes: Included by the design module, the checker and the bench
`ifndef STATIC_BANK_MAP_SVH
`define STATIC_BANK_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SETUP_BASE 8'h00
`define READ_DELAY_BASE 8'h20
`define WRITE_DELAY_BASE 8'h30
`define BURST_READ_DELAY_BASE 8'h40
`define LONG_WAIT_OFFSET 8'h50
`define STATUS_OFFSET 8'h54

// ****************************************
// Bank setup fields
// ****************************************
`define SETUP_WIDTH_LSB 0
`define SETUP_PAGE_BIT 3
`define SETUP_LONG_WAIT_BIT 8
`define SETUP_BUFFER_BIT 19
`define SETUP_PROTECT_BIT 20
`define SETUP_MASK 21'h18_0109
`define SETUP_MASK_W 21'h18_010b

// ****************************************
// Reset values
// ****************************************
`define SETUP_RESET 21'h00_0000
`define DELAY_RESET 5'h1f
`define LONG_WAIT_RESET 10'h000

// ****************************************
// Timing and AHB response codes
// ****************************************
`define LONG_WAIT_SCALE 4
`define HRESP_OKAY 2'h0
`define HRESP_ERROR 2'h1

`endif

// ---- rtl/static_bank_pkg.sv ----
// Purpose: Types shared by the static bank control block and its bench
// Assumes: Four chip-select banks, 28-bit external address, 32-bit data
// Notes: Constants live in the map header
package static_bank_pkg;

   // ****************************************
   // Controller states
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOAD,
      ST_WAIT,
      ST_ERR1,
      ST_ERR2
   } ctrl_state_t;

   // ****************************************
   // External memory pins, driven side
   // ****************************************
   typedef struct packed {
      logic [3:0] cs_n;     // Chip selects, one per bank
      logic oe_n;           // Output enable
      logic we_n;           // Write enable
      logic [27:0] addr;    // External address
      logic [31:0] dout;    // Write data
      logic doe;            // Data bus output enable
   } mem_bus_t;

   // ****************************************
   // Whole block state
   // ****************************************
   typedef struct packed {
      ctrl_state_t st;
      logic [3:0][20:0] setup;     // bank_setup_reg per bank
      logic [3:0][4:0] rd_dly;     // bank_read_delay_reg
      logic [3:0][4:0] wr_dly;     // bank_write_delay_reg
      logic [3:0][4:0] pg_dly;     // bank_burst_read_delay_reg
      logic [9:0] long_cnt;        // long_wait_count_reg
      logic [1:0] bank;
      logic write;
      logic [1:0] size;
      logic [2:0] beats_left;
      logic [1:0] beat;
      logic [13:0] cnt;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic strobe_prev;
      logic hready;
      logic [1:0] hresp;
      logic [7:0] err_count;
      logic [31:0] reg_rdata;
      mem_bus_t mem;
   } ctrl_t;

endpackage

// ---- rtl/static_memory_bank_control.sv ----
// Purpose: Static memory bank control: AHB slave side to four asynchronous memory banks
// Assumes: All inputs synchronous to clk; one outstanding AHB transfer at a time
// Notes: Registers reached over a plain strobe port with read data one cycle later
//
// Chosen here: the placing of the registers and strobed register access.
`include "static_bank_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Operation
// RQ1 - Each bank has its own write-protect bit
// RQ2 - Protected-bank write is dropped, AHB error returned
// RQ3 - Unprotected writes proceed without error, even ROM
// RQ4 - Software protects banks holding ROM
// RQ5 - Normal timing uses per-bank read/write delays
// RQ6 - Long-wait bit selects shared long count timing
// RQ7 - Strobe rising edge ends long-wait access early
// RQ8 - Peripheral toggles strobe per early-ended access
// RQ9 - Idle strobe means full programmed long wait
// RQ10 - Strobe ignored unless bank long-wait enabled
// RQ11 - Software never enables long-wait with page mode
// RQ12 - Buffered bank accesses may be reordered
// RQ13 - Software disables buffering when order matters
// RQ14 - Buffering off for flash commands and writes
// RQ15 - Peripheral banks keep buffering disabled
// RQ16 - Bank width and access size set beat count
// RQ17 - Wide access stalls AHB, narrow beats assembled
// RQ18 - Read delay field gives 1 to 32 waits
// RQ19 - Write delay field gives 1 to 32 waits
// RQ20 - Page delay times later reads in page
// RQ21 - Strobe edges outside long-wait access ignored
module static_memory_bank_control (
   input wire logic clk,
   input wire logic srst,
   // AHB slave
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   output logic hready_out,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // External memory
   output static_bank_pkg::mem_bus_t mem_out,
   input wire logic [31:0] mem_din,
   input wire logic early_done_strobe
);

   // ****************************************
   // State and next state
   // ****************************************
   static_bank_pkg::ctrl_t s_reg;   // Registered state
   static_bank_pkg::ctrl_t s_next;  // Its next value

   // ****************************************
   // Helper functions
   // ****************************************

   // Beats needed: access bytes over bank bytes, at least one
   function automatic logic [2:0] beat_count(input logic [1:0] size, input logic [1:0] width);
      logic [2:0] n;
      n = 3'h1;
      if (size > width) begin
         n = 3'(3'h1 << (size - width)); // RQ16
      end
      return n;
   endfunction

   // Wait states for one beat of the current access
   function automatic logic [13:0] wait_load(input static_bank_pkg::ctrl_t s, input logic [1:0] bank,
                                             input logic write, input logic later);
      logic [20:0] cfg;
      logic [13:0] w;
      cfg = s.setup[bank];
      w = 14'h0001;
      if (cfg[`SETUP_LONG_WAIT_BIT]) begin
         // Long count scaled by sixteen, 16368 waits at most; zero still takes one
         w = {s.long_cnt, 4'h0}; // RQ6
         if (w == 14'h0000) begin
            w = 14'h0001;
         end
      end else if (write) begin
         w = 14'(s.wr_dly[bank]) + 14'h0001; // RQ5 RQ19
      end else if (later && cfg[`SETUP_PAGE_BIT]) begin
         w = 14'(s.pg_dly[bank]) + 14'h0001; // RQ20
      end else begin
         w = 14'(s.rd_dly[bank]) + 14'h0001; // RQ5 RQ18
      end
      return w;
   endfunction

   // Lane mask of a bank width
   function automatic logic [31:0] lane_mask(input logic [1:0] width);
      logic [31:0] m;
      m = 32'hffff_ffff;
      if (width == 2'h0) begin
         m = 32'h0000_00ff;
      end else if (width == 2'h1) begin
         m = 32'h0000_ffff;
      end
      return m;
   endfunction

   // ****************************************
   // Derived combinational terms
   // ****************************************
   logic [1:0] req_bank;       // Bank of the address phase
   logic req_take;             // Address phase accepted this cycle
   logic [1:0] cur_width;      // Width of the bank in service
   logic [4:0] cur_shift;      // Bit offset of the beat in the word
   logic strobe_edge;          // Rising edge of the early strobe
   logic cur_long;             // Bank in service uses long wait
   logic [1:0] reg_idx;        // Bank index of a register access

   assign req_bank = haddr[29:28];
   assign req_take = hsel && htrans[1] && s_reg.hready && (s_reg.st == static_bank_pkg::ST_IDLE);
   assign cur_width = s_reg.setup[s_reg.bank][`SETUP_WIDTH_LSB +: 2];
   assign cur_shift = 5'({s_reg.beat, 3'h0} << cur_width);
   assign strobe_edge = early_done_strobe && !s_reg.strobe_prev;
   assign cur_long = s_reg.setup[s_reg.bank][`SETUP_LONG_WAIT_BIT];
   assign reg_idx = reg_addr[3:2];

   // ****************************************
   // Next-state logic
   // ****************************************
   // One process holds every transition so register writes and transfers
   // stay in step; a delay change lands on the next beat; width and long-wait bits act mid-beat.
   always_comb begin
      s_next = s_reg;
      s_next.strobe_prev = early_done_strobe;  // Edge detector history
      s_next.reg_rdata = 32'h0000_0000;         // Read data stands one cycle only

      // Register writes
      if (reg_wr) begin
         if (reg_addr[7:4] == `SETUP_BASE >> 4) begin
            // Width, page, long wait, buffer and protect bits
            s_next.setup[reg_idx] = reg_wdata[20:0] & `SETUP_MASK_W; // RQ1
         end else if (reg_addr[7:4] == `READ_DELAY_BASE >> 4) begin
            s_next.rd_dly[reg_idx] = reg_wdata[4:0];
         end else if (reg_addr[7:4] == `WRITE_DELAY_BASE >> 4) begin
            s_next.wr_dly[reg_idx] = reg_wdata[4:0];
         end else if (reg_addr[7:4] == `BURST_READ_DELAY_BASE >> 4) begin
            s_next.pg_dly[reg_idx] = reg_wdata[4:0];
         end else if (reg_addr == `LONG_WAIT_OFFSET) begin
            s_next.long_cnt = reg_wdata[9:0];
         end
      end

      // Register reads, unmapped offsets read zero
      if (reg_rd) begin
         if (reg_addr[7:4] == `SETUP_BASE >> 4) begin
            s_next.reg_rdata = {11'h000, s_reg.setup[reg_idx]};
         end else if (reg_addr[7:4] == `READ_DELAY_BASE >> 4) begin
            s_next.reg_rdata = {27'h0, s_reg.rd_dly[reg_idx]};
         end else if (reg_addr[7:4] == `WRITE_DELAY_BASE >> 4) begin
            s_next.reg_rdata = {27'h0, s_reg.wr_dly[reg_idx]};
         end else if (reg_addr[7:4] == `BURST_READ_DELAY_BASE >> 4) begin
            s_next.reg_rdata = {27'h0, s_reg.pg_dly[reg_idx]};
         end else if (reg_addr == `LONG_WAIT_OFFSET) begin
            s_next.reg_rdata = {22'h0, s_reg.long_cnt};
         end else if (reg_addr == `STATUS_OFFSET) begin
            // Busy flag, bank in service, protection-fault count
            s_next.reg_rdata = {16'h0, s_reg.err_count, 5'h0,
                                s_reg.bank, (s_reg.st != static_bank_pkg::ST_IDLE)};
         end
      end

      // Transfer sequencing
      unique case (s_reg.st)
         static_bank_pkg::ST_IDLE: begin
            s_next.hresp = `HRESP_OKAY;
            if (req_take) begin
               s_next.bank = req_bank;
               s_next.write = hwrite;
               s_next.size = hsize[1:0];
               s_next.mem.addr = haddr[27:0];
               s_next.hready = 1'b0;
               if (hwrite && s_reg.setup[req_bank][`SETUP_PROTECT_BIT]) begin
                  // Protected bank: no external cycle, two-cycle error answer
                  s_next.hresp = `HRESP_ERROR; // RQ2
                  s_next.st = static_bank_pkg::ST_ERR1; // RQ2
               end else begin
                  // Unprotected writes go out whatever sits on the bank
                  s_next.st = static_bank_pkg::ST_LOAD; // RQ3
               end
            end
         end
         static_bank_pkg::ST_LOAD: begin
            // Data phase: write data valid now; start first beat
            s_next.wdata = hwdata;
            s_next.rdata = 32'h0000_0000;
            s_next.beat = 2'h0;
            s_next.beats_left = beat_count(s_reg.size, cur_width); // RQ16
            s_next.cnt = wait_load(s_reg, s_reg.bank, s_reg.write, 1'b0);
            s_next.mem.cs_n = ~(4'h1 << s_reg.bank);
            s_next.mem.oe_n = s_reg.write;
            s_next.mem.we_n = ~s_reg.write;
            s_next.mem.doe = s_reg.write;
            s_next.mem.dout = hwdata & lane_mask(cur_width);
            s_next.st = static_bank_pkg::ST_WAIT;
         end
         static_bank_pkg::ST_WAIT: begin
            // Count waits; strobe counts only during a long-wait access
            if (s_reg.cnt == 14'h0001 || (cur_long && strobe_edge)) begin // RQ7 RQ10 RQ21
               if (!s_reg.write) begin
                  // Place this beat's lanes into the assembled word
                  s_next.rdata = s_reg.rdata | ((mem_din & lane_mask(cur_width)) << cur_shift); // RQ17
               end
               if (s_reg.beats_left == 3'h1) begin
                  // Last beat: release pins, finish the AHB data phase
                  s_next.mem.cs_n = 4'hf;
                  s_next.mem.oe_n = 1'b1;
                  s_next.mem.we_n = 1'b1;
                  s_next.mem.doe = 1'b0;
                  s_next.hready = 1'b1;
                  s_next.st = static_bank_pkg::ST_IDLE;
               end else begin
                  // Next narrow beat, AHB held stalled meanwhile
                  s_next.beats_left = s_reg.beats_left - 3'h1; // RQ17
                  s_next.beat = s_reg.beat + 2'h1;
                  // Step by the bank's byte width: one, two or four bytes
                  s_next.mem.addr = s_reg.mem.addr + 28'(3'h1 << cur_width);
                  s_next.mem.dout = (s_reg.wdata >> 5'(cur_shift + 5'(8'h8 << cur_width)))
                                    & lane_mask(cur_width);
                  s_next.cnt = wait_load(s_reg, s_reg.bank, s_reg.write, 1'b1);
               end
            end else begin
               // Idle strobe: run the full programmed wait
               s_next.cnt = s_reg.cnt - 14'h0001; // RQ9
            end
         end
         static_bank_pkg::ST_ERR1: begin
            // Error first cycle, hready low
            s_next.hready = 1'b1;
            s_next.hresp = `HRESP_ERROR; // RQ2
            s_next.err_count = s_reg.err_count + 8'h01;
            s_next.st = static_bank_pkg::ST_ERR2;
         end
         static_bank_pkg::ST_ERR2: begin
            // Error second cycle, then back to idle
            s_next.hresp = `HRESP_OKAY;
            s_next.st = static_bank_pkg::ST_IDLE;
         end
         default: begin
            // Unreachable codes of the three-bit state
            s_next.st = static_bank_pkg::ST_IDLE;
         end
      endcase

      // Reset: quiet pins, safe slow timing, all banks unprotected
      if (srst) begin
         s_next = '0;
         s_next.st = static_bank_pkg::ST_IDLE;
         s_next.setup = {4{`SETUP_RESET}};
         s_next.rd_dly = {4{`DELAY_RESET}};
         s_next.wr_dly = {4{`DELAY_RESET}};
         s_next.pg_dly = {4{`DELAY_RESET}};
         s_next.long_cnt = `LONG_WAIT_RESET;
         s_next.hready = 1'b1;
         s_next.hresp = `HRESP_OKAY;
         s_next.strobe_prev = 1'b1;  // No false edge from a high strobe at release
         s_next.mem.cs_n = 4'hf;
         s_next.mem.oe_n = 1'b1;
         s_next.mem.we_n = 1'b1;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk) begin
      s_reg <= s_next;
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Buffer bit is kept and readable; accesses always run in order, which
   // any buffered bank also permits, so no reordering hazard arises here.
   assign hready_out = s_reg.hready; // RQ12
   assign hresp = s_reg.hresp;
   assign hrdata = s_reg.rdata;
   assign reg_rdata = s_reg.reg_rdata;
   assign mem_out = s_reg.mem;

endmodule // static_memory_bank_control

`default_nettype wire

// ---- verif/static_memory_bank_control_checker.sv ----
// Purpose: Port-level assertions for the static bank control block
// Assumes: Sees only top ports; shadows protect and long-wait bits from register writes
// Notes: Bound into every instance of the block
`include "static_bank_map.svh"
`timescale 1ns/1ps
`default_nettype none
module static_bank_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready_out,
   input wire logic [1:0] hresp,
   input wire logic [31:0] hrdata,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire static_bank_pkg::mem_bus_t mem_out,
   input wire logic [31:0] mem_din,
   input wire logic early_done_strobe
);
   // ****************************************
   // Helper logic
   // ****************************************
   logic [3:0] prot_reg; // Shadow protect bits
   logic [3:0] long_reg; // Shadow long-wait bits
   logic rd_prot_q; // Protect bit of the bank read last cycle
   logic take; // Request accepted this edge
   assign take = hsel && htrans[1] && hready_out && hresp == `HRESP_OKAY;
   // Shadow only setup writes; other offsets leave the bits alone
   always_ff @(posedge clk) begin
      if (srst) begin
         prot_reg <= 4'h0;
         long_reg <= 4'h0;
         rd_prot_q <= 1'b0;
      end else begin
         rd_prot_q <= prot_reg[reg_addr[3:2]];
         if (reg_wr && reg_addr[7:4] == 4'h0) begin
            prot_reg[reg_addr[3:2]] <= reg_wdata[`SETUP_PROTECT_BIT];
            long_reg[reg_addr[3:2]] <= reg_wdata[`SETUP_LONG_WAIT_BIT];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ****************************************
   // Properties
   // ****************************************
   property p_stall; take |=> !hready_out; endproperty
   a_stall: assert property (p_stall) else $error("transfer taken without stall");
   property p_err; take && hwrite && prot_reg[haddr[29:28]]
      |=> !hready_out && hresp == `HRESP_ERROR ##1 hready_out && hresp == `HRESP_ERROR; endproperty
   a_err: assert property (p_err) else $error("protected write without error pair");
   property p_nowe; take && hwrite && prot_reg[haddr[29:28]] |=> (mem_out.we_n == 1'b1) [*3]; endproperty
   a_nowe: assert property (p_nowe) else $error("protected write reached the pins");
   property p_okay; take && !prot_reg[haddr[29:28]] |=> (hresp == `HRESP_OKAY) [*2]; endproperty
   a_okay: assert property (p_okay) else $error("error on unprotected bank");
   property p_we; take && hwrite && !prot_reg[haddr[29:28]] && !long_reg[haddr[29:28]]
      |-> ##[1:40] !mem_out.we_n; endproperty
   a_we: assert property (p_we) else $error("unprotected write never strobed");
   property p_early; $rose(early_done_strobe) && |(~mem_out.cs_n & long_reg)
      |=> mem_out.addr != $past(mem_out.addr) || &mem_out.cs_n; endproperty
   a_early: assert property (p_early) else $error("strobe edge did not end long beat");
   property p_wbeat; !mem_out.we_n |-> mem_out.oe_n && mem_out.doe; endproperty
   a_wbeat: assert property (p_wbeat) else $error("write beat without data drive");
   property p_idle; hready_out && hresp == `HRESP_OKAY && !(hsel && htrans[1]) |=> hready_out; endproperty
   a_idle: assert property (p_idle) else $error("stall without a transfer");
   property p_prot_rb; reg_rd && reg_addr[7:4] == 4'h0 |=> reg_rdata[`SETUP_PROTECT_BIT] == rd_prot_q; endproperty
   a_prot_rb: assert property (p_prot_rb) else $error("protect bit read back wrong");
   c_err: cover property (take && hwrite && prot_reg[haddr[29:28]]);
   c_early: cover property ($rose(early_done_strobe) && |(~mem_out.cs_n & long_reg));
   c_read: cover property (take && !hwrite);
endmodule // static_bank_checker
bind static_memory_bank_control static_bank_checker static_bank_checker_i (.clk(clk), .srst(srst),
   .hsel(hsel), .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready_out(hready_out), .hresp(hresp), .hrdata(hrdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_din(mem_din),
   .early_done_strobe(early_done_strobe));
`default_nettype wire

// ---- verif/static_mem_model.sv ----
// Purpose: Behavioural external memory and slow peripheral for the bank control bench
// Assumes: Read data is an address pattern on every lane
// Notes: Released bus toggles so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module static_mem_model (
   input wire logic clk,
   input wire logic srst,
   input wire static_bank_pkg::mem_bus_t bus,
   input wire logic early_go,
   output logic [31:0] din,
   output logic strobe,
   output int wr_count,
   output logic [31:0] last_wr
);
   logic [31:0] hold_q; // Last value on the data lines
   logic [7:0] age_q; // Cycles into the current beat
   logic [27:0] addr_q; // Address of last cycle
   logic sel_q; // Selected last cycle
   logic we_q; // Write enable of last cycle
   logic sel; // Any bank selected
   assign sel = ~&bus.cs_n;
   // Pattern while read-enabled, inverse of last value when released
   assign din = (sel && !bus.oe_n) ? {4{bus.addr[7:0] ^ 8'h5a}} : ~hold_q;
   // One strobe pulse per beat when asked, none otherwise
   always_ff @(posedge clk) begin
      if (srst) begin
         hold_q <= 32'h0;
         age_q <= 8'h0;
         strobe <= 1'b0;
         wr_count <= 0;
      end else begin
         hold_q <= din;
         age_q <= (!sel || !sel_q || bus.addr != addr_q) ? 8'h0 : age_q + 8'h1;
         strobe <= early_go && sel && age_q == 8'h1;
         if (!bus.we_n && (we_q || bus.addr != addr_q)) begin
            wr_count <= wr_count + 1;
            last_wr <= bus.dout;
         end
      end
      addr_q <= bus.addr;
      sel_q <= sel;
      we_q <= bus.we_n;
   end
endmodule // static_mem_model
`default_nettype wire

// ---- verif/static_memory_bank_control_tb.sv ----
// Purpose: Self-checking bench for the static bank control block
// Assumes: Partner model answers every bank
// Notes: Latency counts cycles from the take edge to hready_out high
`include "static_bank_map.svh"
`timescale 1ns/1ps
`default_nettype none
module static_memory_bank_control_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic early_go = 1'b0;
   logic hready_out;
   logic [1:0] hresp;
   logic [31:0] hrdata;
   logic [31:0] reg_rdata;
   static_bank_pkg::mem_bus_t mem_out;
   logic [31:0] mem_din;
   logic early_done_strobe;
   logic [31:0] last_wr;
   logic [1:0] resp;
   logic [31:0] rd;
   int wr_count;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   int lat;
   int wr0;
   static_memory_bank_control static_memory_bank_control_i (.clk(clk), .srst(srst), .hsel(hsel),
      .htrans(htrans), .haddr(haddr), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready_out(hready_out), .hresp(hresp), .hrdata(hrdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_out(mem_out), .mem_din(mem_din), .early_done_strobe(early_done_strobe));
   static_mem_model static_mem_model_i (.clk(clk), .srst(srst), .bus(mem_out), .early_go(early_go),
      .din(mem_din), .strobe(early_done_strobe), .wr_count(wr_count), .last_wr(last_wr));
   // ****************************************
   // Clock, watchdog and tasks
   // ****************************************
   initial begin
      forever #5 clk = ~clk;
   end
   // Watchdog: whole run needs well under this many cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands one cycle only, then must return to zero
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & mask, exp);
      @(posedge clk);
      #1;
      chk(reg_rdata, 32'h0);
   endtask
   // One AHB transfer; bounded wait for completion
   task automatic ahb(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= s;
      @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      #1;
      lat = 0;
      while (hready_out !== 1'b1 && lat < 3000) begin
         @(posedge clk);
         #1;
         lat++;
      end
      resp = hresp;
      rd = hrdata;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      reg_read(`SETUP_BASE, 32'h0, 32'hffff_ffff);
      reg_read(`READ_DELAY_BASE, 32'h1f, 32'hffff_ffff);
      reg_read(`LONG_WAIT_OFFSET, 32'h0, 32'hffff_ffff);
      reg_read(8'h60, 32'h0, 32'hffff_ffff);
      reg_write(`READ_DELAY_BASE, 32'h0);
      reg_write(`SETUP_BASE + 8'h4, 32'h102);
      reg_write(`LONG_WAIT_OFFSET, 32'h1);
      reg_write(`SETUP_BASE + 8'h8, 32'h2);
      reg_write(`READ_DELAY_BASE + 8'h8, 32'h7);
      reg_write(`SETUP_BASE + 8'hc, 32'h10_0001);
      reg_write(`WRITE_DELAY_BASE + 8'hc, 32'h2);
      reg_read(`SETUP_BASE + 8'hc, 32'h10_0001, 32'hffff_ffff);
      ahb(32'h0000_0010, 1'b0, 3'h2, 32'h0);
      chk(rd, 32'h4948_4b4a);
      chk(32'(lat), 32'h5);
      reg_write(`READ_DELAY_BASE, 32'h3);
      ahb(32'h0000_0010, 1'b0, 3'h2, 32'h0);
      chk(32'(lat), 32'h11);
      ahb(32'h0000_0010, 1'b0, 3'h1, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h4b4a);
      chk(32'(lat), 32'h9);
      // Page mode on bank 0: first beat read delay, later beats page delay
      reg_write(`BURST_READ_DELAY_BASE, 32'h1);
      reg_write(`SETUP_BASE, 32'h8);
      ahb(32'h0000_0010, 1'b0, 3'h2, 32'h0);
      chk(rd, 32'h4948_4b4a);
      chk(32'(lat), 32'hb);
      ahb(32'h1000_0020, 1'b0, 3'h2, 32'h0);
      chk(rd, 32'h7a7a_7a7a);
      chk(32'(lat), 32'h11);
      early_go <= 1'b1;
      ahb(32'h1000_0020, 1'b0, 3'h2, 32'h0);
      chk(rd, 32'h7a7a_7a7a);
      chk(32'(lat < 17), 32'h1);
      ahb(32'h2000_0030, 1'b0, 3'h2, 32'h0);
      chk(rd, 32'h6a6a_6a6a);
      chk(32'(lat), 32'h9);
      early_go <= 1'b0;
      ahb(32'h1000_0040, 1'b1, 3'h2, 32'hc0de_0001);
      chk(32'(lat), 32'h11);
      wr0 = wr_count;
      ahb(32'h3000_0000, 1'b1, 3'h2, 32'h5555_aaaa);
      chk({30'h0, resp}, 32'h1);
      chk(32'(lat), 32'h1);
      chk(32'(wr_count - wr0), 32'h0);
      reg_read(`STATUS_OFFSET, 32'h100, 32'hff00);
      reg_write(`SETUP_BASE + 8'hc, 32'h1);
      ahb(32'h3000_0000, 1'b1, 3'h2, 32'h1234_abcd);
      chk({30'h0, resp}, 32'h0);
      chk(32'(lat), 32'h7);
      chk(32'(wr_count - wr0), 32'h2);
      ahb(32'h2000_0000, 1'b1, 3'h2, 32'hfeed_0123);
      chk(32'(lat), 32'h21);
      chk(last_wr, 32'hfeed_0123);
      tally_and_finish();
   end
endmodule // static_memory_bank_control_tb
`default_nettype wire
